// file: src/pmc_pkg.sv
// Constants for the power mode controller
package pmc_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] power_control_addr = 8'h87;
    localparam logic [7:0] power_control_reset = 8'h00;
    localparam int idle_bit = 0;
    localparam int stop_bit = 1;

    // ****************************************
    // Timing
    // ****************************************
    localparam int clk_period_ns = 20;
    localparam int clk_loss_timeout_us = 100;
    // Longest time, so it rounds down
    localparam int clk_loss_timeout_cycles = (clk_loss_timeout_us * 1000) / clk_period_ns;

    // ****************************************
    // States
    // ****************************************
    typedef enum logic [4:0] {
        pmc_run = 5'h01,
        pmc_idle_pend = 5'h02,
        pmc_idle = 5'h04,
        pmc_stop_pend = 5'h08,
        pmc_stop = 5'h10
    } pmc_state_t;
endpackage

// file: src/pmc_power_ctrl.sv
// Idle and stop power mode controller
// How it works
// (R01) Writing one to idle select halts the core after the current instruction.
// (R02) Idle holds all state; clocks and peripherals keep running.
// (R03) An enabled interrupt in idle clears idle select and resumes the core.
// (R04) After the handler returns, code resumes after the idle-setting instruction.
// (R05) Any reset during idle ends it; normal reset, fetch from address zero.
// (R06) An enabled watchdog timeout resets the chip and ends idle.
// (R07) Software follows the idle-setting instruction with a two-byte instruction.
// (R08) Writing one to stop select halts core and oscillators after the instruction.
// (R09) In stop, interrupts, timers and system clock are off; clock detector runs.
// (R10) Stop ends only on reset, never on an interrupt.
// (R11) Software turns analog blocks off before setting stop select.
// (R12) Enabled missing clock detector resets the chip after its timeout in stop.
// (R13) Stop select always reads as zero.
`timescale 1ns/1ps
`default_nettype none
module pmc_power_ctrl #(
    parameter int loss_cycles = pmc_pkg::clk_loss_timeout_cycles
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    // Core side
    input wire logic instr_done,
    input wire logic irq_enabled_pending,
    output logic cpu_halt,
    output logic irq_service,
    // Reset sources
    input wire logic ext_reset_req,
    input wire logic watchdog_timer_timeout,
    input wire logic missing_clock_detector_en,
    // Clock and reset control
    output logic sys_reset_req,
    output logic osc_run,
    output logic periph_run,
    output logic irq_timer_run
);
    // ****************************************
    // Decode and state
    // ****************************************
    function automatic logic hits_power_control(input logic [7:0] addr);
        hits_power_control = (addr == pmc_pkg::power_control_addr);
    endfunction

    pmc_pkg::pmc_state_t state;
    pmc_pkg::pmc_state_t next_state;
    logic idle_sel;
    logic [15:0] loss_count;
    logic wr_hit;
    logic loss_fire;
    logic any_reset;

    assign wr_hit = sfr_wr && hits_power_control(sfr_addr);
    assign loss_fire = (state == pmc_pkg::pmc_stop) && missing_clock_detector_en &&
                       (loss_count == 16'(loss_cycles - 1));
    assign any_reset = ext_reset_req || watchdog_timer_timeout || loss_fire;

    // ****************************************
    // Mode sequencing
    // ****************************************
    always_comb begin
        next_state = state;
        case (state)
            pmc_pkg::pmc_run: begin
                // (R08) Stop request wins
                if (wr_hit && sfr_wdata[pmc_pkg::stop_bit]) begin
                    next_state = instr_done ? pmc_pkg::pmc_stop : pmc_pkg::pmc_stop_pend;
                // (R01) Idle request
                end else if (wr_hit && sfr_wdata[pmc_pkg::idle_bit]) begin
                    next_state = instr_done ? pmc_pkg::pmc_idle : pmc_pkg::pmc_idle_pend;
                end
            end
            pmc_pkg::pmc_idle_pend: begin
                if (instr_done) begin
                    next_state = pmc_pkg::pmc_idle;
                end
            end
            pmc_pkg::pmc_idle: begin
                // (R03) Wake on enabled interrupt
                if (irq_enabled_pending) begin
                    next_state = pmc_pkg::pmc_run;
                end
            end
            pmc_pkg::pmc_stop_pend: begin
                if (instr_done) begin
                    next_state = pmc_pkg::pmc_stop;
                end
            end
            // (R10) Interrupts ignored in stop
            pmc_pkg::pmc_stop: next_state = pmc_pkg::pmc_stop;
            default: next_state = pmc_pkg::pmc_run;
        endcase
        // (R05) Reset ends any mode
        if (any_reset) begin
            next_state = pmc_pkg::pmc_run;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= pmc_pkg::pmc_run;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // Power control register
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            idle_sel <= pmc_pkg::power_control_reset[pmc_pkg::idle_bit];
        end else if (any_reset) begin
            idle_sel <= pmc_pkg::power_control_reset[pmc_pkg::idle_bit];
        // (R03) Wake clears idle select
        end else if (state == pmc_pkg::pmc_idle && irq_enabled_pending) begin
            idle_sel <= 1'b0;
        end else if (wr_hit && state == pmc_pkg::pmc_run) begin
            idle_sel <= sfr_wdata[pmc_pkg::idle_bit];
        end
    end

    // Unmapped reads answer zero
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd && hits_power_control(sfr_addr)) begin
            // (R13) Stop select reads zero
            sfr_rdata <= {7'h00, idle_sel};
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    // ****************************************
    // Missing clock timeout
    // ****************************************
    // Counts only while stopped; real detector runs off its own oscillator
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            loss_count <= 16'h0000;
        // (R12) Timeout counting in stop
        end else if (state == pmc_pkg::pmc_stop && missing_clock_detector_en && !loss_fire) begin
            loss_count <= loss_count + 16'h0001;
        end else begin
            loss_count <= 16'h0000;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cpu_halt <= 1'b0;
            osc_run <= 1'b1;
            periph_run <= 1'b1;
            irq_timer_run <= 1'b1;
        end else begin
            // (R02) Idle halts core only
            cpu_halt <= (next_state == pmc_pkg::pmc_idle) || (next_state == pmc_pkg::pmc_stop);
            periph_run <= (next_state != pmc_pkg::pmc_stop);
            // (R09) Stop gates clock and timers
            osc_run <= (next_state != pmc_pkg::pmc_stop);
            irq_timer_run <= (next_state != pmc_pkg::pmc_stop);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sys_reset_req <= 1'b0;
            irq_service <= 1'b0;
        end else begin
            // (R06) Watchdog and other resets forwarded
            sys_reset_req <= any_reset;
            // (R04) Core keeps its program counter; handler entered from it
            irq_service <= (state == pmc_pkg::pmc_idle) && irq_enabled_pending && !any_reset;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_idle_write;
        state == pmc_pkg::pmc_run && wr_hit && sfr_wdata[pmc_pkg::idle_bit] &&
            !sfr_wdata[pmc_pkg::stop_bit] && instr_done && !any_reset;
    endsequence

    sequence s_stop_write;
        state == pmc_pkg::pmc_run && wr_hit && sfr_wdata[pmc_pkg::stop_bit] && instr_done && !any_reset;
    endsequence

    a_idle_entry: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R01)
        s_idle_write |=> cpu_halt && osc_run && periph_run && idle_sel)
        else $error("Idle not entered after idle write");

    a_idle_keeps_clocks: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R02)
        state == pmc_pkg::pmc_idle |-> osc_run && irq_timer_run)
        else $error("Clocks stopped in idle");

    a_idle_wake: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R03)
        state == pmc_pkg::pmc_idle && irq_enabled_pending && !any_reset |=> !cpu_halt && irq_service && !idle_sel)
        else $error("Interrupt did not wake idle");

    a_wake_service_once: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R04)
        irq_service |=> !irq_service)
        else $error("Wake service pulse too long");

    a_idle_reset: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R05)
        state == pmc_pkg::pmc_idle && ext_reset_req |=> sys_reset_req && !cpu_halt && !idle_sel)
        else $error("Reset did not end idle");

    a_watchdog_reset: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R06)
        watchdog_timer_timeout |=> sys_reset_req && !cpu_halt && !idle_sel && state == pmc_pkg::pmc_run)
        else $error("Watchdog timeout not forwarded");

    a_stop_entry: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R08)
        s_stop_write |=> cpu_halt && !osc_run && !periph_run)
        else $error("Stop not entered after stop write");

    a_stop_gating: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R09)
        state == pmc_pkg::pmc_stop |-> !irq_timer_run && !osc_run && !periph_run)
        else $error("Timers active in stop");

    a_stop_no_irq_exit: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R10)
        state == pmc_pkg::pmc_stop && !any_reset |=> state == pmc_pkg::pmc_stop && !irq_service)
        else $error("Stop left without reset");

    a_loss_timeout: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R12)
        loss_fire |-> $past(state) == pmc_pkg::pmc_stop ##1 sys_reset_req && !cpu_halt && osc_run)
        else $error("Clock detector timeout did not reset");

    a_stop_reads_zero: assert property (@(posedge ref_clk) disable iff (!reset_n) // (R13)
        sfr_rd |=> !sfr_rdata[pmc_pkg::stop_bit])
        else $error("Stop select read as one");
endmodule // pmc_power_ctrl
`default_nettype wire

// file: verif/pmc_core_model.sv
// Core model: instruction completions and enabled interrupts
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // From the controller
    input wire logic cpu_halt,
    input wire logic irq_service,
    // Bench control
    input wire logic irq_req,
    // To the controller
    output logic instr_done,
    output logic irq_enabled_pending
);
    logic [1:0] instr_cnt;
    // Multi-byte follow-up
    // Four cycles per instruction, never a single-byte one after the idle write
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            instr_cnt <= 2'h0;
            instr_done <= 1'b0;
        end else begin
            instr_cnt <= cpu_halt ? 2'h0 : instr_cnt + 2'h1;
            instr_done <= !cpu_halt && (instr_cnt == 2'h3);
        end
    end
    // Pending drops once the controller hands it to the core
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_enabled_pending <= 1'b0;
        end else begin
            irq_enabled_pending <= irq_req && !irq_service;
        end
    end
endmodule // pmc_core_model
`default_nettype wire

// file: verif/pmc_power_ctrl_tb.sv
// Testbench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module pmc_power_ctrl_tb;
    localparam int loss_span = 8;
    logic ref_clk = 1'b0, reset_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, irq_req = 1'b0;
    logic ext_reset_req = 1'b0, wd_timeout = 1'b0, loss_en = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rd;
    logic instr_done, pend, cpu_halt, irq_service, sys_reset_req, osc_run, periph_run, irq_timer_run;
    int failures = 0, n_checks = 0, n;
    always #10 ref_clk = ~ref_clk;
    pmc_power_ctrl #(.loss_cycles(loss_span)) DUT (.ref_clk(ref_clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .instr_done(instr_done), .irq_enabled_pending(pend), .cpu_halt(cpu_halt), .irq_service(irq_service),
        .ext_reset_req(ext_reset_req), .watchdog_timer_timeout(wd_timeout), .missing_clock_detector_en(loss_en),
        .sys_reset_req(sys_reset_req), .osc_run(osc_run), .periph_run(periph_run), .irq_timer_run(irq_timer_run));
    pmc_core_model core (.ref_clk(ref_clk), .reset_n(reset_n), .cpu_halt(cpu_halt), .irq_service(irq_service),
        .irq_req(irq_req), .instr_done(instr_done), .irq_enabled_pending(pend));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        #1 rd = sfr_rdata;
    endtask
    // Bounded wait for the halt output to reach a level
    task automatic wait_halt(input logic v);
        n = 0;
        #1;
        while (cpu_halt !== v && n < 40) begin
            @(posedge ref_clk);
            #1 n++;
        end
    endtask
    task automatic src_pulse(input int k);
        @(posedge ref_clk);
        if (k == 0) begin
            ext_reset_req <= 1'b1;
        end else begin
            wd_timeout <= 1'b1;
        end
        @(posedge ref_clk);
        ext_reset_req <= 1'b0;
        wd_timeout <= 1'b0;
        #1 chk("reset request", 8'h01, {7'h0, sys_reset_req});
        chk("halt after reset", 8'h00, {7'h0, cpu_halt});
    endtask
    function automatic logic [7:0] runs();
        return {5'h0, osc_run, periph_run, irq_timer_run};
    endfunction
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        rdr(pmc_pkg::power_control_addr); chk("reset value", 8'h00, rd);
        rdr(8'h88); chk("unmapped read", 8'h00, rd);
        $display("test regs done");
    endtask
    task automatic t_idle_irq();
        wr(pmc_pkg::power_control_addr, 8'h01);
        wait_halt(1'b1); chk("idle halt", 8'h01, {7'h0, cpu_halt});
        chk("idle clocks", 8'h07, runs());
        rdr(pmc_pkg::power_control_addr); chk("idle select", 8'h01, rd);
        @(posedge ref_clk) irq_req <= 1'b1;
        wait_halt(1'b0); chk("irq wake", 8'h01, {7'h0, irq_service});
        @(posedge ref_clk) irq_req <= 1'b0;
        rdr(pmc_pkg::power_control_addr); chk("idle cleared", 8'h00, rd);
        $display("test idle_irq done");
    endtask
    task automatic t_idle_reset(input int k);
        wr(pmc_pkg::power_control_addr, 8'h01);
        wait_halt(1'b1); chk("idle halt", 8'h01, {7'h0, cpu_halt});
        src_pulse(k);
        rdr(pmc_pkg::power_control_addr); chk("idle reset", 8'h00, rd);
        $display("test idle_reset done");
    endtask
    task automatic t_stop();
        wr(pmc_pkg::power_control_addr, 8'h03);
        wait_halt(1'b1);
        chk("stop clocks", 8'h00, runs());
        rdr(pmc_pkg::power_control_addr);
        // Idle select written alongside stays set; stop select reads zero
        chk("stop reads", 8'h01, rd);
        @(posedge ref_clk) irq_req <= 1'b1;
        repeat (12) @(posedge ref_clk);
        #1 chk("irq ignored", 8'h01, {7'h0, cpu_halt});
        chk("no detector", 8'h00, {6'h0, irq_service, sys_reset_req});
        @(posedge ref_clk) irq_req <= 1'b0;
        src_pulse(0); chk("stop exit clocks", 8'h07, runs());
        $display("test stop done");
    endtask
    task automatic t_detector();
        @(posedge ref_clk) loss_en <= 1'b1;
        wr(pmc_pkg::power_control_addr, 8'h02);
        wait_halt(1'b1);
        n = 0;
        while (sys_reset_req !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("detector span", 8'h01, {7'h0, n == loss_span});
        chk("detector exit", 8'h07, runs());
        chk("detector halt", 8'h00, {7'h0, cpu_halt});
        @(posedge ref_clk) loss_en <= 1'b0;
        $display("test detector done");
    endtask
    // ****************************************
    // Sequence and verdict
    // ****************************************
    task automatic complete_run();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_regs();
        t_idle_irq();
        t_idle_reset(0);
        t_idle_reset(1);
        t_stop();
        t_detector();
        complete_run();
    end
    initial begin
        #60000;
        failures++;
        complete_run();
    end
endmodule // pmc_power_ctrl_tb
`default_nettype wire
